// [serdes_pkg.sv]
// Purpose: Shared constants and types of the ten-bit serial link framer
// Assumes: One 40 MHz core clock; link pins sampled by the core clock
// Notes:   Offsets are byte addresses on a 32-bit APB
`default_nettype none
package serdes_pkg;
	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	localparam int          WORD_W       = 10;
	localparam int          FRAME_W      = 12;
	localparam logic [11:0] SYNC_FRAME   = 12'h03f;
	localparam int          IGNORE_EDGES = 5;
	localparam int          INIT_EDGES   = 510;
	localparam int          BIT_CYCLES   = 2;
	localparam int          PH_W         = 4;
	localparam int          QUIET_CYCLES = 3 * FRAME_W * BIT_CYCLES;
	localparam int          RX_FLT_RST   = 0;
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_LOCK_CFG = 8'h04;
	localparam logic [7:0]  REG_STATUS   = 8'h08;
	localparam logic [7:0]  REG_RX_WORD  = 8'h0c;
	localparam logic [3:0]  LOCK_CFG_RST = 4'h4;
	localparam int          CTRL_RELOCK  = 0;

	typedef enum logic [1:0] {TX_OFF, TX_INIT, TX_RUN} tx_state_type;
	typedef enum logic [1:0] {RX_HUNT, RX_TRACK, RX_LOCKED} rx_state_type;
endpackage
`default_nettype wire

// [frame_link_if.sv]
// Purpose: Carrier between the framer core and the bit shifter
// Assumes: Single clock domain
// Notes:   take is a one-cycle pulse at each frame boundary
`default_nettype none
interface frame_link_if;
	logic        run;
	logic        take;
	logic [11:0] frame;
	logic        bit_out;
	modport core (output run, output frame, input take, input bit_out);
	modport shifter (input run, input frame, output take, output bit_out);
endinterface
`default_nettype wire

// [pin_filter.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   A level counts once stages two and three agree
`default_nettype none
module pin_filter #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_in,
	output var  logic [W-1:0] level
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] level_nxt;

	// ----------------------------------------------------------------
	// Per-bit agreement
	// ----------------------------------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			level <= '0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			level <= level_nxt;
		end
	end
endmodule // pin_filter
`default_nettype wire

// [frame_shifter.sv]
// Purpose: Shifts twelve-bit frames onto the line, first bit first
// Assumes: Frame supplied combinationally in the cycle take is high
// Notes:   Line bit stays low while run is low
`default_nettype none
module frame_shifter #(
	parameter int BIT_CYCLES = serdes_pkg::BIT_CYCLES
) (
	input  wire logic      clk,
	input  wire logic      rst_n,
	frame_link_if.shifter  lnk
);
	localparam logic [3:0]                  LAST_BIT = 4'(serdes_pkg::FRAME_W - 1);
	localparam logic [serdes_pkg::PH_W-1:0] LAST_CYC = serdes_pkg::PH_W'(BIT_CYCLES - 1);

	logic [11:0]                 sh_r, sh_nxt;
	logic [3:0]                  bit_r, bit_nxt;
	logic [serdes_pkg::PH_W-1:0] cyc_r, cyc_nxt;

	assign lnk.take    = lnk.run && (cyc_r == LAST_CYC) && (bit_r == LAST_BIT);
	assign lnk.bit_out = sh_r[0];

	always_comb begin
		sh_nxt  = sh_r;
		bit_nxt = bit_r;
		cyc_nxt = cyc_r + 1'b1;
		if (!lnk.run) begin
			sh_nxt  = '0;
			bit_nxt = LAST_BIT;
			cyc_nxt = LAST_CYC;
		end else if (lnk.take) begin
			sh_nxt  = lnk.frame; // RULE23
			bit_nxt = '0;
			cyc_nxt = '0;
		end else if (cyc_r == LAST_CYC) begin
			sh_nxt  = {1'b0, sh_r[11:1]}; // RULE9
			bit_nxt = bit_r + 1'b1;
			cyc_nxt = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r  <= '0;
			bit_r <= LAST_BIT;
			cyc_r <= LAST_CYC;
		end else begin
			sh_r  <= sh_nxt;
			bit_r <= bit_nxt;
			cyc_r <= cyc_nxt;
		end
	end

	frame_load_a: assert property (@(posedge clk) disable iff (!rst_n) lnk.take |=> sh_r == $past(lnk.frame)) // RULE9
		else $error("frame not loaded at boundary");
endmodule // frame_shifter
`default_nettype wire

// [serdes_link.sv]
// Purpose: Ten-bit framing serializer and lock-tracking deserializer
// Assumes: All link pins asynchronous; clk doubles as receive reference
// Notes:   One line bit lasts BIT_CYCLES clocks; words faster than a frame are dropped
//
// Behaviour
// [RULE1] Line output stays undriven until transmit init has counted word clocks.
// [RULE2] Sync request sends six ones then six zeros every frame.
// [RULE3] Lock flag stays high while the receiver is still acquiring.
// [RULE4] Pattern sent while either request high, stops once both low.
// [RULE5] Receiver starts acquiring on line transitions, drops lock flag once locked.
// [RULE6] Word captured on rising edge if edge-select high, falling if low.
// [RULE7] Request held five word clocks makes the transmitter ignore input data.
// [RULE8] Each word framed by start bit one and stop bit zero.
// [RULE9] Twelve bits per frame shifted onto the line.
// [RULE10] Source supplies word clock between 20 and 66 MHz; the source model runs it at 5 MHz (200 ns period).
// [RULE11] Data frames only with line enabled, awake and no request.
// [RULE12] Line drive enable low leaves the line output undriven.
// [RULE13] Parallel output counts valid only while lock flag is low.
// [RULE14] Recovered word clock active edge chosen by receive edge select.
// [RULE15] Lost lock raises flag and undrives outputs and recovered clock.
// [RULE16] Host watches lock flag and pulses a sync request on loss.
// [RULE17] Two independent request inputs, either one starts the pattern.
// [RULE18] Parallel input word latched by the transmit word clock.
// [RULE19] System supplies the receiver reference clock.
// [RULE20] Receiver also locks to random data without the pattern.
// [RULE21] Leaving sleep costs 510 word clocks of reinitialisation.
// [RULE22] Receive enable low undrives outputs, lock flag stays driven.
// [RULE23] Frame order: start bit, data bits zero to nine, stop bit.
`default_nettype none
module serdes_link #(
	parameter int BIT_CYCLES = serdes_pkg::BIT_CYCLES,
	parameter int INIT_EDGES = serdes_pkg::INIT_EDGES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        tx_word_clock,
	input  wire logic        tx_edge_select,
	input  wire logic [9:0]  tx_parallel_in,
	input  wire logic        pattern_request_a,
	input  wire logic        pattern_request_b,
	input  wire logic        line_drive_enable,
	input  wire logic        sleep_n,
	output var  logic        line_out,
	output var  logic        line_out_oe,
	input  wire logic        rx_line_in,
	input  wire logic        rx_edge_select,
	input  wire logic        rx_output_enable,
	output var  logic [9:0]  rx_parallel_out,
	output var  logic        rx_parallel_out_oe,
	output var  logic        rx_word_clock,
	output var  logic        rx_word_clock_oe,
	output var  logic        lock_n
);
	localparam logic [serdes_pkg::PH_W-1:0] LAST_CYC  = serdes_pkg::PH_W'(BIT_CYCLES - 1);
	localparam logic [serdes_pkg::PH_W-1:0] MID_CYC   = serdes_pkg::PH_W'(BIT_CYCLES / 2);
	localparam logic [8:0]                  INIT_LAST = 9'(INIT_EDGES - 1);
	localparam logic [7:0]                  QUIET_MAX = 8'(serdes_pkg::QUIET_CYCLES);
	localparam logic [7:0]                  HALF_WORD = 8'(serdes_pkg::FRAME_W * BIT_CYCLES / 2);

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic [18:0] pins_f;
	logic        wclk_f, sel_f, req_a_f, req_b_f, den_f, awake_f, rxl_f, rxsel_f, ren_f;
	logic [9:0]  din_f;

	pin_filter #(.W(19)) u_pins (
		.clk    (clk),
		.rst_n  (rst_n),
		.pin_in ({tx_word_clock, tx_edge_select, tx_parallel_in, pattern_request_a, pattern_request_b,
		          line_drive_enable, sleep_n, rx_line_in, rx_edge_select, rx_output_enable}),
		.level  (pins_f)
	);
	assign {wclk_f, sel_f, din_f, req_a_f, req_b_f, den_f, awake_f, rxl_f, rxsel_f, ren_f} = pins_f;

	// ----------------------------------------------------------------
	// Transmit control
	// ----------------------------------------------------------------
	frame_link_if lnk ();
	frame_shifter #(.BIT_CYCLES(BIT_CYCLES)) u_shift (
		.clk   (clk),
		.rst_n (rst_n),
		.lnk   (lnk)
	);

	serdes_pkg::tx_state_type tx_st_r, tx_st_nxt;
	logic       wclk_d_r, wclk_rise, wclk_fall, cap_edge, req_any, data_ignore;
	logic [8:0] init_r, init_nxt;
	logic [2:0] ign_r, ign_nxt;
	logic [9:0] word_r, word_nxt;
	logic       line_r, line_nxt;

	assign wclk_rise   = wclk_f && !wclk_d_r;
	assign wclk_fall   = !wclk_f && wclk_d_r;
	assign cap_edge    = sel_f ? wclk_rise : wclk_fall; // RULE6
	assign req_any     = req_a_f || req_b_f; // RULE17
	assign data_ignore = (ign_r == 3'(serdes_pkg::IGNORE_EDGES)); // RULE7
	assign lnk.run     = (tx_st_r == serdes_pkg::TX_RUN);
	// Pattern on request, otherwise framed data word
	assign lnk.frame   = req_any ? serdes_pkg::SYNC_FRAME : {1'b0, word_r, 1'b1}; // RULE2 RULE4 RULE8 RULE11
	assign line_out    = line_r;
	assign line_out_oe = lnk.run && den_f && awake_f; // RULE1 RULE12

	always_comb begin
		tx_st_nxt = tx_st_r;
		init_nxt  = init_r;
		ign_nxt   = ign_r;
		word_nxt  = word_r;
		line_nxt  = lnk.bit_out;
		case (tx_st_r)
			serdes_pkg::TX_OFF: begin
				init_nxt = '0;
				if (awake_f) begin
					tx_st_nxt = serdes_pkg::TX_INIT;
				end
			end
			serdes_pkg::TX_INIT: begin
				if (!awake_f) begin
					tx_st_nxt = serdes_pkg::TX_OFF;
				end else if (wclk_rise) begin
					init_nxt = init_r + 1'b1;
					if (init_r == INIT_LAST) begin
						tx_st_nxt = serdes_pkg::TX_RUN; // RULE21
					end
				end
			end
			default: begin
				if (!awake_f) begin
					tx_st_nxt = serdes_pkg::TX_OFF;
				end
			end
		endcase
		if (!req_any) begin
			ign_nxt = '0;
		end else if (wclk_rise && !data_ignore) begin
			ign_nxt = ign_r + 1'b1;
		end
		if (cap_edge && !data_ignore && lnk.run) begin
			word_nxt = din_f; // RULE18
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_r  <= serdes_pkg::TX_OFF;
			init_r   <= '0;
			ign_r    <= '0;
			word_r   <= '0;
			line_r   <= 1'b0;
			wclk_d_r <= 1'b0;
		end else begin
			tx_st_r  <= tx_st_nxt;
			init_r   <= init_nxt;
			ign_r    <= ign_nxt;
			word_r   <= word_nxt;
			line_r   <= line_nxt;
			wclk_d_r <= wclk_f;
		end
	end

	// ----------------------------------------------------------------
	// Receive lock and deframing
	// ----------------------------------------------------------------
	serdes_pkg::rx_state_type rx_st_r, rx_st_nxt;
	logic                        rxl_d_r, line_edge, strobe, frame_end, frame_ok, relock;
	logic [serdes_pkg::PH_W-1:0] ph_r, ph_nxt;
	logic [11:0]                 win_r, win_nxt;
	logic [3:0]                  bitc_r, bitc_nxt, good_r, good_nxt, lock_need;
	logic [7:0]                  quiet_r, quiet_nxt, rck_r, rck_nxt;
	logic [9:0]                  out_r, out_nxt;
	logic                        rclk_r, rclk_nxt;
	logic [3:0]                  lock_cfg_r;

	assign line_edge = rxl_f ^ rxl_d_r;
	// Phase realigns on every transition, which is how the clock is recovered
	assign ph_nxt    = (line_edge || ph_r == LAST_CYC) ? '0 : ph_r + 1'b1;
	assign strobe    = (ph_nxt == MID_CYC);
	assign win_nxt   = strobe ? {rxl_f, win_r[11:1]} : win_r;
	assign frame_end = strobe && (bitc_r == 4'(serdes_pkg::FRAME_W - 1));
	assign frame_ok  = win_nxt[0] && !win_nxt[11]; // RULE23
	assign lock_need = (lock_cfg_r == '0) ? 4'h1 : lock_cfg_r;

	always_comb begin
		rx_st_nxt = rx_st_r;
		bitc_nxt  = strobe ? bitc_r + 1'b1 : bitc_r;
		good_nxt  = good_r;
		quiet_nxt = line_edge ? '0 : ((quiet_r == QUIET_MAX) ? quiet_r : quiet_r + 1'b1);
		out_nxt   = out_r;
		case (rx_st_r)
			serdes_pkg::RX_HUNT: begin
				good_nxt = '0;
				bitc_nxt = '0;
				if (line_edge) begin
					rx_st_nxt = serdes_pkg::RX_TRACK; // RULE5
				end
			end
			serdes_pkg::RX_TRACK: begin
				if (frame_end && frame_ok) begin
					bitc_nxt = '0;
					good_nxt = good_r + 1'b1;
					if (good_r + 1'b1 >= lock_need) begin
						rx_st_nxt = serdes_pkg::RX_LOCKED; // RULE5 RULE20
					end
				end else if (frame_end) begin
					// Slip one bit: the next bit closes a shifted window
					good_nxt = '0;
					bitc_nxt = bitc_r;
				end
			end
			default: begin
				if (frame_end && frame_ok) begin
					bitc_nxt = '0;
					out_nxt  = win_nxt[10:1];
				end else if (frame_end) begin
					rx_st_nxt = serdes_pkg::RX_HUNT; // RULE15
				end
			end
		endcase
		if (relock || (rx_st_r != serdes_pkg::RX_HUNT && quiet_r == QUIET_MAX)) begin
			rx_st_nxt = serdes_pkg::RX_HUNT;
		end
		// Inactive level at the word change, active edge half a word later
		rck_nxt  = (rck_r == '0) ? '0 : rck_r - 1'b1;
		rclk_nxt = rclk_r;
		if (out_nxt != out_r || (frame_end && rx_st_r == serdes_pkg::RX_LOCKED)) begin
			rck_nxt  = HALF_WORD;
			rclk_nxt = !rxsel_f; // RULE14
		end else if (rck_r == 8'h01) begin
			rclk_nxt = rxsel_f; // RULE14
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r <= serdes_pkg::RX_HUNT;
			rxl_d_r <= 1'b0;
			ph_r    <= '0;
			win_r   <= '0;
			bitc_r  <= '0;
			good_r  <= '0;
			quiet_r <= '0;
			out_r   <= '0;
			rck_r   <= '0;
			rclk_r  <= 1'b0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rxl_d_r <= rxl_f;
			ph_r    <= ph_nxt;
			win_r   <= win_nxt;
			bitc_r  <= bitc_nxt;
			good_r  <= good_nxt;
			quiet_r <= quiet_nxt;
			out_r   <= out_nxt;
			rck_r   <= rck_nxt;
			rclk_r  <= rclk_nxt;
		end
	end

	assign lock_n             = (rx_st_r != serdes_pkg::RX_LOCKED); // RULE3
	assign rx_parallel_out    = out_r;
	assign rx_word_clock      = rclk_r;
	assign rx_parallel_out_oe = !lock_n && ren_f; // RULE13 RULE15 RULE22
	assign rx_word_clock_oe   = !lock_n && ren_f; // RULE15 RULE22

	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------
	logic        wr_acc, rd_setup, mapped;
	logic [31:0] rd_val, prdata_nxt;
	logic [3:0]  lock_cfg_nxt;

	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign mapped   = (paddr == serdes_pkg::REG_CTRL) || (paddr == serdes_pkg::REG_LOCK_CFG)
	                  || (paddr == serdes_pkg::REG_STATUS) || (paddr == serdes_pkg::REG_RX_WORD);
	assign relock   = wr_acc && (paddr == serdes_pkg::REG_CTRL) && pwdata[serdes_pkg::CTRL_RELOCK];
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;
	logic [31:0] prdata_r_q;

	assign prdata   = prdata_r_q;

	always_comb begin
		if (paddr == serdes_pkg::REG_LOCK_CFG) begin
			rd_val = {28'h0, lock_cfg_r};
		end else if (paddr == serdes_pkg::REG_STATUS) begin
			rd_val = {27'h0, line_out_oe, data_ignore, req_any, lnk.run, lock_n};
		end else if (paddr == serdes_pkg::REG_RX_WORD) begin
			rd_val = {22'h0, out_r};
		end else begin
			rd_val = 32'h0;
		end
		prdata_nxt   = rd_setup ? rd_val : prdata_r_q;
		lock_cfg_nxt = (wr_acc && paddr == serdes_pkg::REG_LOCK_CFG) ? pwdata[3:0] : lock_cfg_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r_q <= '0;
			lock_cfg_r <= serdes_pkg::LOCK_CFG_RST;
		end else begin
			prdata_r_q <= prdata_nxt;
			lock_cfg_r <= lock_cfg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	tx_hiz_init_a: assert property (tx_st_r != serdes_pkg::TX_RUN |-> !line_out_oe) // RULE1
		else $error("line driven before init done");
	sync_frame_a: assert property (lnk.take && req_any |=> ##[1:2] line_out) // RULE2
		else $error("pattern does not open with ones");
	lock_flag_a: assert property ($fell(lock_n) |-> $past(rx_st_r) == serdes_pkg::RX_TRACK // RULE3
		&& $past(frame_end && frame_ok))
		else $error("lock flag low while acquiring");
	data_frame_a: assert property (lnk.take && !req_any |-> lnk.frame[0] && !lnk.frame[11] // RULE8
		&& lnk.frame[10:1] == word_r)
		else $error("data frame malformed");
	cap_edge_a: assert property (word_r != $past(word_r) |-> $past(cap_edge) && $past(sel_f) == $past(wclk_f)) // RULE6
		else $error("word captured off the selected edge");
	data_ignore_a: assert property (data_ignore |=> word_r == $past(word_r)) // RULE7
		else $error("data taken while ignored");
	line_hiz_a: assert property (!den_f || !awake_f |-> !line_out_oe) // RULE12
		else $error("line driven while disabled");
	rx_valid_a: assert property (rx_parallel_out_oe |-> !lock_n && ren_f) // RULE13
		else $error("output valid without lock");
	loss_a: assert property (rx_st_r == serdes_pkg::RX_LOCKED && frame_end && !frame_ok // RULE15
		|=> lock_n && !rx_parallel_out_oe && !rx_word_clock_oe)
		else $error("lock loss not flagged");
	init_count_a: assert property ($rose(lnk.run) |-> $past(init_r) == INIT_LAST) // RULE21
		else $error("init count wrong");
	ren_hiz_a: assert property (!ren_f |-> !rx_parallel_out_oe && !rx_word_clock_oe) // RULE22
		else $error("outputs driven with receive disabled");
endmodule // serdes_link
`default_nettype wire

// [serdes_source_model.sv]
// Purpose: Source device model: free word clock and parallel words
// Assumes: Word clock period 200 ns, phase unrelated to the core clock
// Notes:   word_rise is steady around rising edges, word_fall around falling ones
`default_nettype none
module serdes_source_model (
	output var  logic       word_clock,
	output var  logic [9:0] word,
	input  wire logic [9:0] word_rise,
	input  wire logic [9:0] word_fall
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Word clock and data
	// ----------------------------------------------------------------
	// Slowed to a rate the sampled core can follow; data moves mid-phase
	initial begin
		word_clock = 1'b0;
		word = 10'h000;
		#7;
		forever begin
			word_clock = 1'b1;
			#50 word = word_fall;
			#50 word_clock = 1'b0;
			#50 word = word_rise;
			#50;
		end
	end
endmodule // serdes_source_model
`default_nettype wire

// [serdes_link_tb.sv]
// Purpose: Self-checking bench of the framing serializer and deserializer
// Assumes: Line looped back from transmitter to receiver
// Notes:   Short init count of 8 word clocks keeps the run brief
`default_nettype none
module serdes_link_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        tx_word_clock, tx_edge_select, pattern_request_a, pattern_request_b;
	logic        line_drive_enable, sleep_n, line_out, line_out_oe, rx_line_in;
	logic        rx_edge_select, rx_output_enable, rx_parallel_out_oe, rx_word_clock, rx_word_clock_oe, lock_n;
	logic [9:0]  tx_parallel_in, rx_parallel_out, word_rise, word_fall;
	int          fails, num_checks;
	// ----------------------------------------------------------------
	// Clock, loopback and instances
	// ----------------------------------------------------------------
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	// Undriven line keeps changing so a stale level cannot pass for data
	always @(posedge clk) rx_line_in <= !rst_n ? 1'b0 : line_out_oe ? line_out : ~rx_line_in;
	serdes_source_model src_u (.word_clock(tx_word_clock), .word(tx_parallel_in),
		.word_rise(word_rise), .word_fall(word_fall));
	serdes_link #(.INIT_EDGES(8)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_word_clock(tx_word_clock), .tx_edge_select(tx_edge_select), .tx_parallel_in(tx_parallel_in),
		.pattern_request_a(pattern_request_a), .pattern_request_b(pattern_request_b),
		.line_drive_enable(line_drive_enable), .sleep_n(sleep_n), .line_out(line_out),
		.line_out_oe(line_out_oe), .rx_line_in(rx_line_in), .rx_edge_select(rx_edge_select),
		.rx_output_enable(rx_output_enable), .rx_parallel_out(rx_parallel_out),
		.rx_parallel_out_oe(rx_parallel_out_oe), .rx_word_clock(rx_word_clock),
		.rx_word_clock_oe(rx_word_clock_oe), .lock_n(lock_n));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			fails++;
			$display("unexpected bus wait: expected ready, seen none");
			finish_test();
		end
	endtask
	// Bounded wait: 0 lock flag, 1 line enable, 2 received word
	task automatic wait_for(input int which, input logic [9:0] exp, input int limit);
		logic [9:0] v;
		for (int n = 0; n < limit; n++) begin
			@(negedge clk);
			v = which == 0 ? {9'h0, lock_n} : which == 1 ? {9'h0, line_out_oe} : rx_parallel_out;
			if (v === exp) begin
				num_checks++;
				return;
			end
		end
		fails++;
		$display("unexpected wait %0d: expected %h, seen %h", which, exp, v);
		finish_test();
	endtask
	task automatic check_sync_frame;
		logic [11:0] got;
		logic        prev;
		prev = 1'b1;
		got = 12'h000;
		for (int n = 0; n < 100; n++) begin
			@(negedge clk);
			if (prev === 1'b0 && line_out === 1'b1) break;
			prev = line_out;
		end
		for (int i = 0; i < 12; i++) begin
			got[i] = line_out;
			repeat (2) @(negedge clk);
		end
		check_word("sync frame", {20'h0, serdes_pkg::SYNC_FRAME}, {20'h0, got});
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, err, rd} = '0;
		{tx_edge_select, line_drive_enable, sleep_n, rx_edge_select, rx_output_enable} = 5'h1f;
		{pattern_request_a, pattern_request_b} = 2'h0;
		word_rise = 10'h007;
		word_fall = 10'h3ff;
		fails = 0;
		num_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check_bit("lock flag at reset", 1'b1, lock_n);
		apb_xfer(1'b0, serdes_pkg::REG_LOCK_CFG, 32'h0);
		check_word("lock config", {28'h0, serdes_pkg::LOCK_CFG_RST}, rd);
		apb_xfer(1'b1, 8'h10, 32'h1);
		check_bit("unmapped error", 1'b1, err);
		apb_xfer(1'b1, serdes_pkg::REG_STATUS, 32'hffff_ffff);
		check_bit("read-only error", 1'b0, err);
		repeat (10) @(negedge clk);
		check_bit("line enable in init", 1'b0, line_out_oe);
		$display("test reset done");
		wait_for(1, 10'h1, 400);
		wait_for(0, 10'h0, 3000);
		repeat (60) @(negedge clk);
		check_word("word on rise", 32'h7, {22'h0, rx_parallel_out});
		$display("test random lock done");
		@(posedge clk);
		tx_edge_select <= 1'b0;
		wait_for(2, 10'h3ff, 300);
		check_bit("recovered clock at update", 1'b0, rx_word_clock);
		repeat (13) @(negedge clk);
		check_bit("recovered clock active", 1'b1, rx_word_clock);
		@(posedge clk);
		rx_edge_select <= 1'b0;
		repeat (27) @(negedge clk);
		check_bit("recovered clock inverted", 1'b0, rx_word_clock);
		@(posedge clk);
		rx_edge_select <= 1'b1;
		$display("test edge select done");
		for (int r = 0; r < 2; r++) begin
			@(posedge clk);
			pattern_request_a <= r == 0;
			pattern_request_b <= r == 1;
			repeat (60) @(negedge clk);
			check_sync_frame();
			check_word("pattern word", 32'h1f, {22'h0, rx_parallel_out});
			apb_xfer(1'b0, serdes_pkg::REG_STATUS, 32'h0);
			check_word("request status", 32'hc, rd & 32'hc);
			@(posedge clk);
			pattern_request_a <= 1'b0;
			pattern_request_b <= 1'b0;
			wait_for(2, 10'h3ff, 300);
		end
		$display("test pattern done");
		@(posedge clk);
		line_drive_enable <= 1'b0;
		wait_for(1, 10'h0, 10);
		wait_for(0, 10'h1, 300);
		check_bit("word enable lost", 1'b0, rx_parallel_out_oe);
		check_bit("clock enable lost", 1'b0, rx_word_clock_oe);
		@(posedge clk);
		line_drive_enable <= 1'b1;
		wait_for(0, 10'h0, 3000);
		@(posedge clk);
		rx_output_enable <= 1'b0;
		repeat (10) @(negedge clk);
		check_bit("word enable off", 1'b0, rx_parallel_out_oe);
		check_bit("clock enable off", 1'b0, rx_word_clock_oe);
		check_bit("lock kept", 1'b0, lock_n);
		@(posedge clk);
		rx_output_enable <= 1'b1;
		$display("test enables done");
		apb_xfer(1'b1, serdes_pkg::REG_CTRL, 32'h1);
		wait_for(0, 10'h1, 5);
		@(posedge clk);
		pattern_request_b <= 1'b1;
		wait_for(0, 10'h0, 3000);
		@(posedge clk);
		pattern_request_b <= 1'b0;
		$display("test relock done");
		@(posedge clk);
		sleep_n <= 1'b0;
		wait_for(1, 10'h0, 10);
		@(posedge clk);
		sleep_n <= 1'b1;
		repeat (40) @(negedge clk);
		check_bit("line enable after wake", 1'b0, line_out_oe);
		wait_for(1, 10'h1, 200);
		$display("test sleep done");
		finish_test();
	end
endmodule // serdes_link_tb
`default_nettype wire
